/* include/lrc_pkg.sv */
package lrc_pkg;
	// ********************************
	// widths and encodings
	// ********************************
	localparam int MEAS_W = 24;
	localparam int SEC_W = 32;
	localparam int DAY_SEC_W = 17;
	localparam int CMD_N = 8;
	localparam int CMD_IDX_W = 3;
	localparam logic [31:0] MAX_ON_DISABLED = 32'hffffffff; // -1 disables
	localparam logic [DAY_SEC_W-1:0] SECS_PER_DAY = 17'h15180;
	localparam logic [SEC_W-1:0] SECS_PER_WEEK = 32'h00093a80;
	localparam logic [SEC_W-1:0] SEC_ZERO = 32'h00000000;
	localparam logic [15:0] OCC_ZERO = 16'h0000;

	typedef enum logic [1:0] {LRC_MODE_OFF, LRC_MODE_ON, LRC_MODE_AUTO}
		lrc_mode_t;
	typedef enum logic [3:0] {
		LRC_P_BATT_V, LRC_P_BATT_SOC, LRC_P_BATT_TEMP, LRC_P_SOLAR_ONGRID,
		LRC_P_AC_POWER, LRC_P_SOLAR_EXCESS, LRC_P_SCHEDULE, LRC_P_ON_SRC,
		LRC_P_OFF_SRC, LRC_P_CMD, LRC_P_ALARM
	} lrc_preset_t;
	typedef enum logic [1:0] {LRC_AL_ERR, LRC_AL_WARN, LRC_AL_BOTH}
		lrc_alarm_sel_t;
	typedef enum logic [1:0] {LRC_RNG_NONE, LRC_RNG_COUNT, LRC_RNG_DATE}
		lrc_range_t;

	// measurements and system status, same clock domain
	typedef struct packed {
		logic signed [MEAS_W-1:0] batt_v;
		logic signed [MEAS_W-1:0] batt_soc;
		logic signed [MEAS_W-1:0] batt_temp;
		logic signed [MEAS_W-1:0] export_power;
		logic signed [MEAS_W-1:0] ac_power;
		logic                     solar_limited;
		logic                     on_source;
		logic                     inv_running;
		logic [CMD_N-1:0]         cmd_in;
		logic                     alarm_err;
		logic                     alarm_warn;
	} lrc_meas_t;

	typedef struct packed {
		logic signed [MEAS_W-1:0] activation_threshold;
		logic signed [MEAS_W-1:0] deactivation_threshold;
		logic [CMD_IDX_W-1:0]     cmd_idx;
		lrc_alarm_sel_t           alarm_sel;
	} lrc_cond_cfg_t;

	typedef struct packed {
		logic [SEC_W-1:0]     start_date;
		logic [DAY_SEC_W-1:0] start_tod;
		logic [DAY_SEC_W-1:0] end_tod;
		logic [6:0]           weekdays;
		logic [7:0]           recur_weeks;
		lrc_range_t           range;
		logic [15:0]          occ_limit;
		logic [SEC_W-1:0]     end_date;
	} lrc_sched_cfg_t;

	typedef struct packed {
		logic [15:0]          act_delay;
		logic [15:0]          deact_delay;
		logic [15:0]          min_on;
		logic [15:0]          min_off;
		logic [31:0]          max_on;
		logic [DAY_SEC_W-1:0] allow_t1;
		logic [DAY_SEC_W-1:0] allow_t2;
		logic [6:0]           allow_days;
	} lrc_temp_cfg_t;

	// time source, all same clock domain
	typedef struct packed {
		logic                 sec_tick;
		logic [SEC_W-1:0]     epoch_sec;
		logic [DAY_SEC_W-1:0] tod_sec;
		logic [2:0]           weekday;  // 0 monday .. 6 sunday
	} lrc_time_t;

	localparam int RESET_CNT = 0;
endpackage

/* logic/lrc_controller.sv */
// Contract
// (R1) on-grid solar excess: hysteresis on exported power
// (R2) solar excess: any converter power limited
// (R3) schedule: disabled before starting date
// (R4) schedule: on at start, off at end
// (R5) schedule: selected weekdays only
// (R6) schedule: active only every Nth week
// (R7) schedule ranges: endless, occurrence count, end date
// (R8) on-source: condition while on external source
// (R9) off-source: running and no source
// (R10) command preset: indexed command input
// (R11) alarm preset: errors, warnings or either
// (R12) hysteresis for five measured presets
// (R13) act below deact: on low, off high
// (R14) act above deact: inverted hysteresis
// (R15) all presets but schedule get restriction
// (R16) activation delay filters short true pulses
// (R17) deactivation delay filters short false pulses
// (R18) minimum on and off hold times
// (R19) maximum on time, minus one disables
// (R20) max-on expiry locks off until clear
// (R21) activation only inside daily window
// (R22) weekday mask, bit6 monday, bit0 sunday
// (R23) manual off, manual on, auto preset
// (R24) all counters on one-second tick; occ_cnt steps on schedule window openings instead
`timescale 1ns/1ps
`default_nettype none

module lrc_controller (
	input  wire logic                    i_clk,
	input  wire logic                    i_rstn,
	input  wire lrc_pkg::lrc_mode_t      i_mode,
	input  wire lrc_pkg::lrc_preset_t    i_preset,
	input  wire lrc_pkg::lrc_meas_t      i_meas,
	input  wire lrc_pkg::lrc_cond_cfg_t  i_cond_cfg,
	input  wire lrc_pkg::lrc_sched_cfg_t i_sched_cfg,
	input  wire lrc_pkg::lrc_temp_cfg_t  i_temp_cfg,
	input  wire lrc_pkg::lrc_time_t      i_time,
	output logic                         o_relay,
	output logic                         o_locked,
	output logic                         o_condition
);
	// ********************************
	// state
	// ********************************
	typedef enum logic [1:0] {LRC_S_OFF, LRC_S_ON, LRC_S_LOCK} lrc_out_st_t;
	typedef struct packed {
		logic        hyst;       // hysteresis latch
		logic        cond;       // registered preset condition
		lrc_out_st_t st;
		logic [15:0] dly_cnt;    // seconds condition differs from output
		logic [15:0] hold_cnt;   // seconds in current output state
		logic [31:0] on_cnt;     // seconds on, for max-on
		logic        sched_on;
		logic        in_window;  // previous cycle inside schedule window
		logic [15:0] occ_cnt;
		logic        relay;
	} lrc_state_t;

	// one register holds every bit of state so reset clears it all at once;
	// hold_cnt and occ_cnt saturate rather than wrap, so a long idle never looks short
	lrc_state_t state_reg;
	lrc_state_t state_next;

	// ********************************
	// helpers
	// ********************************
	// weekday 0=monday maps to mask bit 6, sunday to bit 0
	function automatic logic day_allowed(input logic [6:0] mask,
	                                     input logic [2:0] wd);
		logic [2:0] bitpos;
		// a weekday code of seven does not exist; the range test keeps it
		// from reading past the top of the mask
		bitpos = 3'h6 - wd;
		day_allowed = (wd <= 3'h6) && mask[bitpos]; // see (R5) (R22)
	endfunction

	// time-of-day window, wraps past midnight when t1 > t2
	function automatic logic tod_in(input logic [16:0] t1,
	                                input logic [16:0] t2,
	                                input logic [16:0] now);
		if (t1 <= t2) begin
			tod_in = (now >= t1) && (now < t2);
		end else begin
			tod_in = (now >= t1) || (now < t2);
		end
	endfunction

	// hysteresis step; direction follows threshold order
	function automatic logic hyst_step(input logic cur,
	                                   input logic signed [23:0] v,
	                                   input logic signed [23:0] act,
	                                   input logic signed [23:0] deact);
		hyst_step = cur;
		if (act < deact) begin
			if (v <= act) hyst_step = 1'b1;   // see (R13)
			if (v >= deact) hyst_step = 1'b0; // see (R13)
		end else begin
			if (v >= act) hyst_step = 1'b1;   // see (R14)
			if (v <= deact) hyst_step = 1'b0; // see (R14)
		end
	endfunction

	logic signed [lrc_pkg::MEAS_W-1:0] hyst_val;
	logic                              is_hyst;
	logic                              raw_cond;
	logic [lrc_pkg::SEC_W-1:0]         since_start;
	logic [lrc_pkg::SEC_W-1:0]         week_idx;
	logic                              week_ok;
	logic                              range_ok;
	logic                              win_now;
	logic                              allow_ok;
	logic                              sec;

	// ********************************
	// preset condition
	// ********************************
	// the hysteresis latch is shared; presets without thresholds hold it
	// at zero so that a later switch to a measured preset starts clean
	always_comb begin
		is_hyst = 1'b1;
		hyst_val = i_meas.batt_v;
		case (i_preset)
			lrc_pkg::LRC_P_BATT_V:       hyst_val = i_meas.batt_v;
			lrc_pkg::LRC_P_BATT_SOC:     hyst_val = i_meas.batt_soc;
			lrc_pkg::LRC_P_BATT_TEMP:    hyst_val = i_meas.batt_temp;
			lrc_pkg::LRC_P_SOLAR_ONGRID:
				hyst_val = i_meas.export_power; // see (R1)
			lrc_pkg::LRC_P_AC_POWER:     hyst_val = i_meas.ac_power;
			default:                     is_hyst = 1'b0; // see (R12)
		endcase
	end

	always_comb begin
		case (i_preset)
			lrc_pkg::LRC_P_SOLAR_EXCESS:
				raw_cond = i_meas.solar_limited; // see (R2)
			lrc_pkg::LRC_P_ON_SRC:       raw_cond = i_meas.on_source; // see (R8)
			lrc_pkg::LRC_P_OFF_SRC:
				raw_cond = i_meas.inv_running && !i_meas.on_source; // see (R9)
			lrc_pkg::LRC_P_CMD:
				raw_cond = i_meas.cmd_in[i_cond_cfg.cmd_idx]; // see (R10)
			lrc_pkg::LRC_P_ALARM: begin
				case (i_cond_cfg.alarm_sel) // see (R11)
					lrc_pkg::LRC_AL_ERR:  raw_cond = i_meas.alarm_err;
					lrc_pkg::LRC_AL_WARN: raw_cond = i_meas.alarm_warn;
					default: raw_cond = i_meas.alarm_err || i_meas.alarm_warn;
				endcase
			end
			default:                     raw_cond = state_reg.hyst;
		endcase
	end

	// ********************************
	// schedule qualifiers
	// ********************************
	// week counting starts at the starting date itself
	// the divider is wide but used once; it trades area for an exact week
	// index with no running counter that could fall out of step
	always_comb begin
		since_start = i_time.epoch_sec - i_sched_cfg.start_date;
		week_idx = since_start / lrc_pkg::SECS_PER_WEEK;
		week_ok = (i_sched_cfg.recur_weeks <= 8'h01) ||
			((week_idx % {24'h000000, i_sched_cfg.recur_weeks}) ==
			lrc_pkg::SEC_ZERO); // see (R6)
		case (i_sched_cfg.range) // see (R7)
			lrc_pkg::LRC_RNG_COUNT:
				range_ok = state_reg.occ_cnt < i_sched_cfg.occ_limit;
			lrc_pkg::LRC_RNG_DATE:
				range_ok = i_time.epoch_sec < i_sched_cfg.end_date;
			default: range_ok = 1'b1;
		endcase
		win_now = (i_time.epoch_sec >= i_sched_cfg.start_date) && // see (R3)
			tod_in(i_sched_cfg.start_tod, i_sched_cfg.end_tod,
			i_time.tod_sec) && // see (R4)
			day_allowed(i_sched_cfg.weekdays, i_time.weekday) && week_ok;
		allow_ok = tod_in(i_temp_cfg.allow_t1, i_temp_cfg.allow_t2,
			i_time.tod_sec) && // see (R21)
			day_allowed(i_temp_cfg.allow_days, i_time.weekday); // see (R22)
	end

	// ********************************
	// next state
	// ********************************
	// the seconds tick paces the delay, hold and on-time counters so timing is whole seconds
	always_comb begin
		state_next = state_reg;
		sec = i_time.sec_tick; // see (R24)
		if (is_hyst) begin
			state_next.hyst = hyst_step(state_reg.hyst, hyst_val,
				i_cond_cfg.activation_threshold, i_cond_cfg.deactivation_threshold);
		end else begin
			state_next.hyst = 1'b0;
		end
		state_next.cond = raw_cond;

		// schedule: an occurrence is counted at each window opening that the range allows, saturating at 16'hffff
		state_next.in_window = win_now;
		if (win_now && !state_reg.in_window && range_ok &&
			state_reg.occ_cnt != 16'hffff) begin
			state_next.occ_cnt = state_reg.occ_cnt + 16'h0001;
		end
		// a running occurrence finishes its window even if the range ends
		// meanwhile; a window that opens with the range already spent stays
		// off for its whole length instead of turning on one cycle late
		state_next.sched_on = win_now && (range_ok || state_reg.sched_on);

		// temporal restriction
		// hold_cnt starts from zero at reset, so the minimum off time also
		// applies to the very first activation after power-up
		if (sec && state_reg.hold_cnt != 16'hffff) begin
			state_next.hold_cnt = state_reg.hold_cnt + 16'h0001;
		end
		case (state_reg.st)
			LRC_S_OFF: begin
				if (state_reg.cond && allow_ok) begin
					if (sec) begin
						state_next.dly_cnt = state_reg.dly_cnt + 16'h0001;
					end
				end else begin
					state_next.dly_cnt = 16'h0000; // see (R16)
				end
				if (state_reg.cond && allow_ok &&
					state_reg.dly_cnt >= i_temp_cfg.act_delay && // see (R16)
					state_reg.hold_cnt >= i_temp_cfg.min_off) begin // see (R18)
					state_next.st = LRC_S_ON;
					state_next.dly_cnt = 16'h0000;
					state_next.hold_cnt = 16'h0000;
					state_next.on_cnt = 32'h00000000;
				end
			end
			LRC_S_ON: begin
				if (sec) begin
					state_next.on_cnt = state_reg.on_cnt + 32'h00000001;
				end
				if (!state_reg.cond) begin
					if (sec) begin
						state_next.dly_cnt = state_reg.dly_cnt + 16'h0001;
					end
				end else begin
					state_next.dly_cnt = 16'h0000; // see (R17)
				end
				if (i_temp_cfg.max_on != lrc_pkg::MAX_ON_DISABLED &&
					state_reg.on_cnt >= i_temp_cfg.max_on) begin // see (R19)
					// forced off ignores min on: the limit is a safety cut
					state_next.st = state_reg.cond ? LRC_S_LOCK : LRC_S_OFF;
					state_next.dly_cnt = 16'h0000;
					state_next.hold_cnt = 16'h0000;
				end else if (!state_reg.cond &&
					state_reg.dly_cnt >= i_temp_cfg.deact_delay && // see (R17)
					state_reg.hold_cnt >= i_temp_cfg.min_on) begin // see (R18)
					state_next.st = LRC_S_OFF;
					state_next.dly_cnt = 16'h0000;
					state_next.hold_cnt = 16'h0000;
				end
			end
			LRC_S_LOCK: begin
				// no timer ends a lockout: only a falling condition or
				// manual off lets the relay try again
				if (!state_reg.cond) begin
					state_next.st = LRC_S_OFF; // see (R20)
				end
			end
			default: state_next.st = LRC_S_OFF;
		endcase

		// output select; manual off also clears any lockout
		case (i_mode)
			lrc_pkg::LRC_MODE_ON: state_next.relay = 1'b1; // see (R23)
			lrc_pkg::LRC_MODE_AUTO: begin
				if (i_preset == lrc_pkg::LRC_P_SCHEDULE) begin
					state_next.relay = state_reg.sched_on; // see (R15)
				end else begin
					state_next.relay = (state_next.st == LRC_S_ON); // see (R15)
				end
			end
			default: begin
				state_next.relay = 1'b0; // see (R23)
				state_next.st = LRC_S_OFF; // see (R20)
				state_next.dly_cnt = 16'h0000;
			end
		endcase
	end

	// ********************************
	// registers
	// ********************************
	// synchronous reset: the relay stays released until the first clock
	// edge with reset high, matching the unpowered state of the coil
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// o_relay and o_condition come straight from flip-flops, so the coil driver never
	// sees a glitch from the decode logic above
	assign o_relay = state_reg.relay;
	assign o_locked = (state_reg.st == LRC_S_LOCK);
	assign o_condition = state_reg.cond;
endmodule

`default_nettype wire

/* test/lrc_controller_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module lrc_chk (
	input wire logic                    i_clk,
	input wire logic                    i_rstn,
	input wire lrc_pkg::lrc_mode_t      i_mode,
	input wire lrc_pkg::lrc_preset_t    i_preset,
	input wire lrc_pkg::lrc_meas_t      i_meas,
	input wire lrc_pkg::lrc_cond_cfg_t  i_cond_cfg,
	input wire lrc_pkg::lrc_sched_cfg_t i_sched_cfg,
	input wire lrc_pkg::lrc_temp_cfg_t  i_temp_cfg,
	input wire lrc_pkg::lrc_time_t      i_time,
	input wire logic                    o_relay,
	input wire logic                    o_locked,
	input wire logic                    o_condition
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// each property ties an output to its cause at the inputs or, for the lock checks, at the other outputs
	a_reset_clears_out: assert property (
		disable iff (1'b0)
		!i_rstn |=> !o_relay && !o_locked && !o_condition)
		else $error("output high after reset");
	a_manual_relay: assert property (
		i_mode != lrc_pkg::LRC_MODE_AUTO
		|=> o_relay == ($past(i_mode) == lrc_pkg::LRC_MODE_ON))
		else $error("manual mode not followed");
	// the schedule preset bypasses the restriction stage, lock included
	a_lock_holds_off: assert property (
		o_locked && i_mode == lrc_pkg::LRC_MODE_AUTO
		&& i_preset != lrc_pkg::LRC_P_SCHEDULE |=> !o_relay)
		else $error("relay on while locked");
	a_lock_release: assert property (
		o_locked && !o_condition |-> ##[1:3] !o_locked)
		else $error("lock kept after condition cleared");
	a_sched_before_start: assert property (
		(i_mode == lrc_pkg::LRC_MODE_AUTO
		&& i_preset == lrc_pkg::LRC_P_SCHEDULE
		&& i_time.epoch_sec < i_sched_cfg.start_date) [*3] |-> !o_relay)
		else $error("schedule on before start date");
	a_window_shut: assert property (
		(i_mode == lrc_pkg::LRC_MODE_AUTO
		&& i_preset != lrc_pkg::LRC_P_SCHEDULE
		&& i_temp_cfg.allow_t1 == i_temp_cfg.allow_t2) [*3]
		|-> !$rose(o_relay))
		else $error("relay rose with empty window");
	a_onsrc_cond: assert property (
		i_preset == lrc_pkg::LRC_P_ON_SRC
		|=> o_condition == $past(i_meas.on_source))
		else $error("source condition wrong");
	a_cmd_cond: assert property (
		i_preset == lrc_pkg::LRC_P_CMD
		|=> o_condition == $past(i_meas.cmd_in[i_cond_cfg.cmd_idx]))
		else $error("command condition wrong");
endmodule
bind lrc_controller lrc_chk u_chk (.i_clk, .i_rstn, .i_mode, .i_preset,
	.i_meas, .i_cond_cfg, .i_sched_cfg, .i_temp_cfg, .i_time, .o_relay,
	.o_locked, .o_condition);
`default_nettype wire

/* test/lrc_time_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// system time source
// ****
module lrc_time_src (
	input  wire logic              i_clk,
	input  wire logic              i_load,
	input  wire logic [31:0]       i_epoch,
	input  wire logic [16:0]       i_tod,
	input  wire logic [2:0]        i_wd,
	output var lrc_pkg::lrc_time_t o_time
);
	logic [1:0] div = 2'h0;
	// a second lasts four clocks so delays stay short; weekday is fixed
	always @(posedge i_clk) begin
		div <= div + 2'h1;
		o_time.sec_tick <= (div == 2'h3);
		o_time.weekday <= i_wd;
		if (i_load) begin
			o_time.epoch_sec <= i_epoch;
			o_time.tod_sec <= i_tod;
		end else if (div == 2'h3) begin
			o_time.epoch_sec <= o_time.epoch_sec + 32'h1;
			o_time.tod_sec <= o_time.tod_sec + 17'h1;
		end
	end
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module tb;
	logic                    clk = 1'b0;
	logic                    rstn = 1'b0;
	logic                    ld = 1'b1;
	logic                    relay, lck, cnd;
	logic [31:0]             r;
	lrc_pkg::lrc_mode_t      mode = lrc_pkg::LRC_MODE_OFF;
	lrc_pkg::lrc_preset_t    pre = lrc_pkg::LRC_P_ON_SRC;
	lrc_pkg::lrc_meas_t      m = '0;
	lrc_pkg::lrc_cond_cfg_t  cc = '0;
	lrc_pkg::lrc_sched_cfg_t sc = '0;
	lrc_pkg::lrc_temp_cfg_t  tc = '0;
	lrc_pkg::lrc_time_t      tm;
	integer                  seed = 32'h8361559c;
	int                      n_fail = 0, tests_run = 0, cyc = 0;
	int                      lat = 0, v, k;
	lrc_time_src u_time (.i_clk(clk), .i_load(ld), .i_epoch(32'h000aae60),
		.i_tod(17'h00064), .i_wd(3'h2), .o_time(tm));
	lrc_controller u_dut (.i_clk(clk), .i_rstn(rstn), .i_mode(mode),
		.i_preset(pre), .i_meas(m), .i_cond_cfg(cc), .i_sched_cfg(sc),
		.i_temp_cfg(tc), .i_time(tm), .o_relay(relay), .o_locked(lck),
		.o_condition(cnd));
	// 100 ns clock
	always #50 clk = ~clk;
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	task chk(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %b want %b", $time, got, exp);
		end
	endtask
	task cyc_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task wait_out(input logic exp);
		for (k = 0; k < 60 && relay !== exp; k++)
			cyc_n(1);
		chk(relay, exp);
	endtask
	task print_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// reference for the plain presets; latch value for the rest
	function automatic logic cond_of();
		case (pre)
		lrc_pkg::LRC_P_SOLAR_EXCESS: return m.solar_limited;
		lrc_pkg::LRC_P_ON_SRC: return m.on_source;
		lrc_pkg::LRC_P_OFF_SRC: return m.inv_running & !m.on_source;
		lrc_pkg::LRC_P_CMD: return m.cmd_in[cc.cmd_idx];
		lrc_pkg::LRC_P_ALARM: return cc.alarm_sel == lrc_pkg::LRC_AL_ERR ?
			m.alarm_err : cc.alarm_sel == lrc_pkg::LRC_AL_WARN ?
			m.alarm_warn : m.alarm_err | m.alarm_warn;
		default: return lat[0];
		endcase
	endfunction
	// main sequence: inputs change only on falling edges
	initial begin
		cyc_n(16);
		rstn = 1'b1;
		ld = 1'b0;
		mode = lrc_pkg::LRC_MODE_ON;
		cyc_n(2);
		chk(relay, 1'b1);
		mode = lrc_pkg::LRC_MODE_OFF;
		cyc_n(2);
		chk(relay, 1'b0);
		$display("test manual done");
		mode = lrc_pkg::LRC_MODE_AUTO;
		for (int i = 0; i < 60; i++) begin
			pre = lrc_pkg::lrc_preset_t'(4'(i % 5));
			cc.activation_threshold = (i < 30) ? 24'h64 : 24'hc8;
			cc.deactivation_threshold = (i < 30) ? 24'hc8 : 24'h64;
			v = 50 + int'($unsigned($random(seed)) % 200);
			{m.batt_v, m.batt_soc, m.batt_temp} = {3{24'(v)}};
			{m.export_power, m.ac_power} = {2{24'(v)}};
			if (i < 30 ? v >= 200 : v <= 100) lat = 0;
			else if (i < 30 ? v <= 100 : v >= 200) lat = 1;
			cyc_n(3);
			chk(cnd, lat[0]);
		end
		for (int i = 0; i < 60; i++) begin
			pre = lrc_pkg::lrc_preset_t'(4'(i % 6 == 1 ? 10 : 5 + i % 6));
			cc.cmd_idx = 3'(i / 6);
			cc.alarm_sel = lrc_pkg::lrc_alarm_sel_t'(2'(i / 6 % 4));
			r = $random(seed);
			{m.solar_limited, m.on_source, m.inv_running, m.cmd_in,
				m.alarm_err, m.alarm_warn} = r[12:0];
			cyc_n(2);
			chk(cnd, cond_of());
		end
		$display("test conditions done");
		pre = lrc_pkg::LRC_P_ON_SRC;
		m = '0;
		tc.act_delay = 16'h2;
		tc.deact_delay = 16'h3;
		tc.max_on = lrc_pkg::MAX_ON_DISABLED;
		tc.allow_t2 = lrc_pkg::SECS_PER_DAY;
		tc.allow_days = 7'h7f;
		cyc_n(12);
		m.on_source = 1'b1;
		cyc_n(3);
		m.on_source = 1'b0;
		repeat (12) begin
			cyc_n(1);
			chk(relay, 1'b0);
		end
		m.on_source = 1'b1;
		cyc_n(2);
		chk(relay, 1'b0);
		wait_out(1'b1);
		m.on_source = 1'b0;
		cyc_n(3);
		m.on_source = 1'b1;
		repeat (10) begin
			cyc_n(1);
			chk(relay, 1'b1);
		end
		tc.max_on = 32'h3;
		for (k = 0; k < 60 && lck !== 1'b1; k++)
			cyc_n(1);
		chk(lck, 1'b1);
		repeat (20) begin
			cyc_n(1);
			chk(relay, 1'b0);
		end
		m.on_source = 1'b0;
		tc.max_on = lrc_pkg::MAX_ON_DISABLED;
		cyc_n(6);
		chk(lck, 1'b0);
		tc.allow_days = 7'h6f; // wednesday masked
		m.on_source = 1'b1;
		cyc_n(20);
		chk(relay, 1'b0);
		tc.allow_days = 7'h7f;
		tc.allow_t2 = 17'h0;
		cyc_n(20);
		chk(relay, 1'b0);
		tc.allow_t2 = lrc_pkg::SECS_PER_DAY;
		wait_out(1'b1);
		// no delays left, so only the minimum times can hold the relay
		tc.deact_delay = 16'h0;
		tc.min_on = 16'h8;
		m.on_source = 1'b0;
		cyc_n(16);
		chk(relay, 1'b1);
		wait_out(1'b0);
		tc.act_delay = 16'h0;
		tc.min_off = 16'h8;
		m.on_source = 1'b1;
		cyc_n(16);
		chk(relay, 1'b0);
		wait_out(1'b1);
		$display("test temporal done");
		pre = lrc_pkg::LRC_P_SCHEDULE;
		sc.start_tod = 17'h32;
		sc.end_tod = 17'h1000;
		sc.weekdays = 7'h7f;
		sc.recur_weeks = 8'h2;
		sc.start_date = 32'h000f4240;
		cyc_n(8);
		chk(relay, 1'b0);
		sc.start_date = '0;
		cyc_n(8);
		chk(relay, 1'b0);
		sc.recur_weeks = 8'h1;
		sc.range = lrc_pkg::LRC_RNG_DATE;
		sc.end_date = 32'h1;
		cyc_n(8);
		chk(relay, 1'b0);
		sc.range = lrc_pkg::LRC_RNG_NONE;
		cyc_n(8);
		chk(relay, 1'b1);
		sc.weekdays = 7'h0;
		cyc_n(8);
		chk(relay, 1'b0);
		// count range: a spent limit keeps the opening window dark
		sc.weekdays = 7'h7f;
		sc.range = lrc_pkg::LRC_RNG_COUNT;
		sc.occ_limit = lrc_pkg::OCC_ZERO;
		cyc_n(8);
		chk(relay, 1'b0);
		sc.occ_limit = 16'hffff;
		cyc_n(8);
		chk(relay, 1'b1);
		// end of day window a few seconds ahead of the time source
		sc.end_tod = tm.tod_sec + 17'h3;
		cyc_n(4);
		chk(relay, 1'b1);
		cyc_n(16);
		chk(relay, 1'b0);
		$display("test schedule done");
		print_verdict();
	end
endmodule
`default_nettype wire
